// ==== logic/udrq_pkg.sv ====
// Purpose: constants for the uart data path and receive queue registers
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers
// Notes:   byte offsets equal the printed offsets
package udrq_pkg;
  localparam logic [7:0] OFF_RX_CHAR      = 8'h24;
  localparam logic [7:0] OFF_TX_CHAR      = 8'h28;
  localparam logic [7:0] OFF_CONFIG       = 8'h2c;
  localparam logic [7:0] OFF_STATUS       = 8'h30;
  localparam logic [7:0] OFF_INT_STATUS   = 8'h34;
  localparam logic [7:0] OFF_INT_MASK     = 8'h38;
  localparam logic [7:0] OFF_COHERENCE    = 8'hc0;
  localparam logic [7:0] OFF_RXQ_CS       = 8'hd0;

  localparam int CHAR_W        = 9;
  localparam int QUEUE_DEPTH   = 4;
  localparam int QCNT_W        = 3;

  localparam int CHC_HCM_BIT   = 0;
  localparam int CHC_EARLY_PARITY_ERROR_FLAG_BIT = 8;
  localparam logic [31:0] CHC_RESET = 32'h0000_0000;

  localparam int RFCS_EARLY_NACK_ENABLE_BIT = 0;
  localparam int RFCS_RX_QUEUE_ENABLE_BIT   = 8;
  localparam int RFCS_RX_QUEUE_FULL_INT_ENABLE_BIT  = 9;
  localparam int RFCS_RFE_BIT    = 10;
  localparam int RFCS_RFF_BIT    = 11;
  localparam int RFCS_CNT_LSB    = 12;
  localparam int RFCS_RX_QUEUE_FULL_INT_FLAG_BIT = 15;
  localparam logic [31:0] RFCS_RESET = 32'h0000_0400;

  localparam int CFG_PARITY_CHECK_ENABLE_BIT   = 0;
  localparam int CFG_WL9_BIT    = 1;
  localparam int CFG_DEEP_SLEEP_OPERATION_ENABLE_BIT   = 2;
  localparam int CFG_SC_BIT     = 3;
  localparam int CFG_FLUSH_BIT  = 4;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  localparam int ST_RECEIVE_BUFFER_NOT_EMPTY_FLAG_BIT    = 0;
  localparam int ST_TBE_BIT     = 1;
  localparam int ST_OVERRUN_ERROR_FLAG_BIT   = 2;

  localparam int EV_RX_BIT      = 0;
  localparam int EV_OVR_BIT     = 1;
  localparam int EV_PERR_BIT    = 2;
  localparam int EV_QFULL_BIT   = 3;
  localparam int EV_W           = 4;

  localparam int NACK_EARLY_SUB = 16;
endpackage

// ==== logic/udrq_top.sv ====
// Purpose: uart data registers, coherence control and receive queue
// Assumes: AHB-Lite slave, zero wait state, frame engine outside feeds rx/tx strobes
// Notes:   nack timing output counts in sixteenths of a bit time
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps

// Function
// - receive register shows held character, or oldest queued character with queue active, in bits 8:0, rest zero
// - with parity on, character msb read holds received parity bit
// - transmit bits 8:0; parity replaces msb when parity is on
// - early parity flag set on bad parity sample; writing 0 clears it
// - coherence mode 0: request to send follows receive not empty
// - coherence mode 1: request to send high after last data bit sampled
// - coherence register reserved bits always read zero
// - queue empty flag bit 10, set after reset
// - queue full flag bit 11 when no room left
// - queue count in bits 14:12
// - queue full interrupt flag bit 15, signalled only when bit 9 set
// - queue enable bit 8 takes effect only with deep sleep enable set
// - smartcard early nack starts nack one sixteenth bit earlier on parity error
// - receive not empty cleared by data read or flush command
// - overrun set when new word arrives while receive not empty and the queue is inactive or full
module udrq_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_last_bit_sampled,
  input  wire logic        rx_parity_bad,
  input  wire logic        rx_word_valid,
  input  wire logic [8:0]  rx_word,
  output logic             tx_word_valid,
  output logic      [8:0]  tx_word,
  input  wire logic        tx_word_taken,
  input  wire logic        rx_word_taken_n,
  output logic      [4:0]  nack_start_sixteenths,
  output logic             request_to_send_out_n,
  output logic             irq
);
  localparam logic [4:0] NACK_NORMAL = 5'(udrq_pkg::NACK_EARLY_SUB);

  logic [31:0] cfg_q;
  logic        hcm_q, early_parity_error_flag_q, early_nack_enable_q, rx_queue_enable_q, rx_queue_full_int_enable_q, rx_queue_full_int_flag_q;
  logic        receive_buffer_not_empty_flag_q, overrun_error_flag_q, tbe_q, rts_q;
  logic [8:0]  rx_hold_q;
  logic [8:0]  queue_q [udrq_pkg::QUEUE_DEPTH];
  logic [1:0]  rd_ptr_q, wr_ptr_q;
  logic [2:0]  cnt_q;
  logic [8:0]  tx_q;
  logic [udrq_pkg::EV_W-1:0] ist_q, imask_q;
  logic        ap_wr_q, ap_rd_q;
  logic [7:0]  ap_addr_q;
  logic        ap_word_q;
  logic [31:0] rdata_d;

  logic parity_on, wl9, q_active, q_full, q_empty;
  logic pop, push, rd_rx, wr_tx, flush;
  logic [udrq_pkg::EV_W-1:0] ev;
  logic perr_ev, ovr_ev, q_was_active_q;

  function automatic logic [8:0] apply_parity(input logic [8:0] c, input logic on,
                                              input logic nine);
    logic [8:0] r;
    r = c;
    if (on && nine) begin
      r[8] = ^c[7:0];
    end else if (on) begin
      r[7] = ^c[6:0];
      r[8] = 1'b0;
    end else if (!nine) begin
      r[8] = 1'b0;
    end
    return r;
  endfunction

  function automatic logic [2:0] next_count(input logic [2:0] c, input logic add,
                                             input logic sub);
    return c + 3'(add) - 3'(sub);
  endfunction

  function automatic logic reg_hit(input logic v, input logic [7:0] a,
                                   input logic [7:0] off);
    return v && (a == off);
  endfunction

  assign parity_on = cfg_q[udrq_pkg::CFG_PARITY_CHECK_ENABLE_BIT];
  assign wl9       = cfg_q[udrq_pkg::CFG_WL9_BIT];
  assign q_active  = rx_queue_enable_q && cfg_q[udrq_pkg::CFG_DEEP_SLEEP_OPERATION_ENABLE_BIT];
  assign q_full    = (cnt_q == 3'(udrq_pkg::QUEUE_DEPTH));
  assign q_empty   = (cnt_q == 3'h0);

  // bus decode; data phase registers
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_rx = reg_hit(ap_rd_q, ap_addr_q, udrq_pkg::OFF_RX_CHAR);
  // sub-word writes to word-only registers are ignored
  assign wr_tx = ap_word_q && reg_hit(ap_wr_q, ap_addr_q, udrq_pkg::OFF_TX_CHAR);
  assign flush = reg_hit(ap_wr_q, ap_addr_q, udrq_pkg::OFF_CONFIG)
                 && hwdata[udrq_pkg::CFG_FLUSH_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q   <= 1'b0;
      ap_rd_q   <= 1'b0;
      ap_addr_q <= 8'h00;
      ap_word_q <= 1'b0;
    end else if (hready) begin
      ap_wr_q   <= hsel && htrans[1] && hwrite;
      ap_rd_q   <= hsel && htrans[1] && !hwrite;
      ap_addr_q <= {haddr[7:2], 2'b00};
      ap_word_q <= (hsize == 3'h2);
    end
  end

  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q    <= udrq_pkg::CFG_RESET;
      hcm_q    <= 1'b0;
      early_nack_enable_q <= 1'b0;
      rx_queue_enable_q   <= 1'b0;
      rx_queue_full_int_enable_q  <= 1'b0;
      imask_q  <= '0;
    end else if (ap_wr_q) begin
      case (ap_addr_q)
        udrq_pkg::OFF_CONFIG: begin
          cfg_q <= {28'h0, hwdata[3:0]};
        end
        udrq_pkg::OFF_COHERENCE: begin
          hcm_q <= hwdata[udrq_pkg::CHC_HCM_BIT];
        end
        udrq_pkg::OFF_RXQ_CS: begin
          if (ap_word_q) begin
            early_nack_enable_q <= hwdata[udrq_pkg::RFCS_EARLY_NACK_ENABLE_BIT];
            rx_queue_enable_q   <= hwdata[udrq_pkg::RFCS_RX_QUEUE_ENABLE_BIT];
            rx_queue_full_int_enable_q  <= hwdata[udrq_pkg::RFCS_RX_QUEUE_FULL_INT_ENABLE_BIT];
          end
        end
        udrq_pkg::OFF_INT_MASK: begin
          imask_q <= hwdata[udrq_pkg::EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // early parity flag: set wins over the write-0 clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      early_parity_error_flag_q <= 1'b0;
    end else if (perr_ev) begin
      early_parity_error_flag_q <= 1'b1;
    end else if (reg_hit(ap_wr_q, ap_addr_q, udrq_pkg::OFF_COHERENCE)
                 && !hwdata[udrq_pkg::CHC_EARLY_PARITY_ERROR_FLAG_BIT]) begin
      early_parity_error_flag_q <= 1'b0;
    end
  end

  // receive path: holding register or queue
  assign push = rx_word_valid && q_active && !q_full;
  assign pop  = rd_rx && q_active && !q_empty;
  assign perr_ev = rx_last_bit_sampled && rx_parity_bad && parity_on;
  assign ovr_ev  = rx_word_valid && receive_buffer_not_empty_flag_q && (!q_active || q_full);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ptr_q <= 2'h0;
      wr_ptr_q <= 2'h0;
      cnt_q    <= 3'h0;
    end else if (flush || !q_active) begin
      rd_ptr_q <= 2'h0;
      wr_ptr_q <= 2'h0;
      cnt_q    <= 3'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 2'h1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 2'h1;
      end
      cnt_q <= next_count(cnt_q, push, pop);
    end
  end

  always_ff @(posedge hclk) begin
    if (push) begin
      queue_q[wr_ptr_q] <= rx_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_hold_q <= 9'h000;
    end else if (rx_word_valid && !q_active) begin
      rx_hold_q <= rx_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_was_active_q <= 1'b0;
    end else begin
      q_was_active_q <= q_active;
    end
  end

  // receive not empty and overrun
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      receive_buffer_not_empty_flag_q  <= 1'b0;
      overrun_error_flag_q <= 1'b0;
    end else begin
      if (q_active) begin
        receive_buffer_not_empty_flag_q <= next_count(cnt_q, push, pop) != 3'h0;
      end else if (rx_word_valid) begin
        receive_buffer_not_empty_flag_q <= 1'b1;
      // a queue just switched off leaves no word behind
      end else if (rd_rx || flush || q_was_active_q) begin
        receive_buffer_not_empty_flag_q <= 1'b0;
      end
      if (flush && q_active) begin
        receive_buffer_not_empty_flag_q <= 1'b0;
      end
      if (ovr_ev) begin
        overrun_error_flag_q <= 1'b1;
      end else if (reg_hit(ap_wr_q, ap_addr_q, udrq_pkg::OFF_STATUS)
                   && hwdata[udrq_pkg::ST_OVERRUN_ERROR_FLAG_BIT]) begin
        overrun_error_flag_q <= 1'b0;
      end
    end
  end

  // queue full interrupt flag, cleared when a pop makes room
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_queue_full_int_flag_q <= 1'b0;
    end else if (push && !pop && cnt_q == 3'(udrq_pkg::QUEUE_DEPTH - 1)) begin
      rx_queue_full_int_flag_q <= 1'b1;
    end else if (pop || flush || !q_active) begin
      rx_queue_full_int_flag_q <= 1'b0;
    end
  end

  // transmit path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_q          <= 9'h000;
      tbe_q         <= 1'b1;
      tx_word_valid <= 1'b0;
      tx_word       <= 9'h000;
    end else begin
      if (wr_tx && tbe_q) begin
        tx_q          <= hwdata[8:0];
        tbe_q         <= 1'b0;
        tx_word_valid <= 1'b1;
        tx_word       <= apply_parity(hwdata[8:0], parity_on, wl9);
      end else if (tx_word_taken) begin
        tbe_q         <= 1'b1;
        tx_word_valid <= 1'b0;
      end
    end
  end

  // request to send policy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rts_q <= 1'b0;
    end else if (rx_last_bit_sampled) begin
      rts_q <= 1'b1;
    end else if (!receive_buffer_not_empty_flag_q && rx_word_taken_n) begin
      rts_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      request_to_send_out_n <= 1'b0;
    end else begin
      request_to_send_out_n <= hcm_q ? rts_q : receive_buffer_not_empty_flag_q;
    end
  end

  // smartcard nack timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nack_start_sixteenths <= NACK_NORMAL;
    end else if (cfg_q[udrq_pkg::CFG_SC_BIT] && early_nack_enable_q && rx_parity_bad) begin
      nack_start_sixteenths <= NACK_NORMAL - 5'h01;
    end else begin
      nack_start_sixteenths <= NACK_NORMAL;
    end
  end

  // sticky events, cleared by reading the interrupt status
  assign ev = {rx_queue_full_int_flag_q && rx_queue_full_int_enable_q,
               perr_ev,
               ovr_ev,
               rx_word_valid};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ist_q <= '0;
    end else if (reg_hit(ap_rd_q, ap_addr_q, udrq_pkg::OFF_INT_STATUS)) begin
      ist_q <= ev;
    end else begin
      ist_q <= ist_q | ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_q & imask_q);
    end
  end

  // read mux in the data phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (ap_addr_q)
      udrq_pkg::OFF_RX_CHAR: begin
        rdata_d[8:0] = q_active ? queue_q[rd_ptr_q] : rx_hold_q;
      end
      udrq_pkg::OFF_TX_CHAR: begin
        rdata_d[8:0] = tx_q;
      end
      udrq_pkg::OFF_CONFIG: begin
        rdata_d = cfg_q;
      end
      udrq_pkg::OFF_STATUS: begin
        rdata_d[udrq_pkg::ST_RECEIVE_BUFFER_NOT_EMPTY_FLAG_BIT]  = receive_buffer_not_empty_flag_q;
        rdata_d[udrq_pkg::ST_TBE_BIT]   = tbe_q;
        rdata_d[udrq_pkg::ST_OVERRUN_ERROR_FLAG_BIT] = overrun_error_flag_q;
      end
      udrq_pkg::OFF_INT_STATUS: begin
        rdata_d[udrq_pkg::EV_W-1:0] = ist_q;
      end
      udrq_pkg::OFF_INT_MASK: begin
        rdata_d[udrq_pkg::EV_W-1:0] = imask_q;
      end
      udrq_pkg::OFF_COHERENCE: begin
        rdata_d[udrq_pkg::CHC_HCM_BIT]   = hcm_q;
        rdata_d[udrq_pkg::CHC_EARLY_PARITY_ERROR_FLAG_BIT] = early_parity_error_flag_q;
      end
      udrq_pkg::OFF_RXQ_CS: begin
        rdata_d[udrq_pkg::RFCS_EARLY_NACK_ENABLE_BIT] = early_nack_enable_q;
        rdata_d[udrq_pkg::RFCS_RX_QUEUE_ENABLE_BIT]   = rx_queue_enable_q;
        rdata_d[udrq_pkg::RFCS_RX_QUEUE_FULL_INT_ENABLE_BIT]  = rx_queue_full_int_enable_q;
        rdata_d[udrq_pkg::RFCS_RFE_BIT]    = q_empty;
        rdata_d[udrq_pkg::RFCS_RFF_BIT]    = q_full;
        rdata_d[udrq_pkg::RFCS_CNT_LSB +: udrq_pkg::QCNT_W] = cnt_q;
        rdata_d[udrq_pkg::RFCS_RX_QUEUE_FULL_INT_FLAG_BIT] = rx_queue_full_int_flag_q;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  assign hrdata = ap_rd_q ? rdata_d : 32'h0000_0000;
endmodule

// ==== dv/udrq_assertions.sv ====
// Purpose: port checks for the uart data and receive queue registers
// Assumes: zero wait AHB-Lite slave, reads data phase one cycle after address
// Notes:   bound to udrq_top
`timescale 1ns/1ps
module udrq_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        rx_parity_bad,
  input wire logic        tx_word_valid,
  input wire logic [8:0]  tx_word,
  input wire logic        tx_word_taken,
  input wire logic [4:0]  nack_start_sixteenths
);
  logic       rd_q;
  logic [7:0] ra_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      ra_q <= 8'h00;
    end else begin
      rd_q <= hsel & htrans[1] & hready & !hwrite;
      ra_q <= haddr[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_idle_rdata: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data not zero outside a read");
  a_rx_upper: assert property (
    rd_q && ra_q == 8'h24 |-> hrdata[31:9] == 23'h0) else $error("rx upper bits set");
  a_chc_zero: assert property (
    rd_q && ra_q == 8'hc0 |-> hrdata[31:9] == 23'h0 && hrdata[7:1] == 7'h0)
    else $error("coherence reserved bits set");
  a_queue_empty: assert property (
    rd_q && ra_q == 8'hd0 |-> hrdata[10] == (hrdata[14:12] == 3'h0))
    else $error("empty flag disagrees with count");
  a_queue_full: assert property (
    rd_q && ra_q == 8'hd0 |-> hrdata[11] == (hrdata[14:12] == 3'h4))
    else $error("full flag disagrees with count");
  a_fullint_full: assert property (
    rd_q && ra_q == 8'hd0 && hrdata[15] |-> hrdata[11]) else $error("full int without full");
  a_nack_early: assert property (
    nack_start_sixteenths == 5'h0f |-> $past(rx_parity_bad)) else $error("early nack uncaused");
  a_nack_values: assert property (
    nack_start_sixteenths == 5'h10 || nack_start_sixteenths == 5'h0f)
    else $error("nack start out of range");
  a_tx_hold: assert property (
    tx_word_valid && !tx_word_taken |=> tx_word_valid && $stable(tx_word))
    else $error("tx word changed while waiting");
endmodule

bind udrq_top udrq_checker i_udrq_checker (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .rx_parity_bad, .tx_word_valid, .tx_word, .tx_word_taken,
  .nack_start_sixteenths);

// ==== dv/udrq_link_model.sv ====
// Purpose: far side frame engine of the uart link
// Assumes: one clock, signals change after a rising edge
// Notes:   take_wait sets how slowly the transmitter takes a word
`timescale 1ns/1ps
module udrq_link_model (
  input  wire logic       hclk,
  input  wire logic       tx_word_valid,
  input  wire logic [8:0] tx_word,
  output logic            rx_last_bit_sampled,
  output logic            rx_parity_bad,
  output logic            rx_word_valid,
  output logic      [8:0] rx_word,
  output logic            tx_word_taken,
  output logic            rx_word_taken_n
);
  int         take_wait = 0;
  logic [8:0] tx_seen = 9'h000;
  initial begin
    rx_last_bit_sampled = 1'b0;
    rx_parity_bad = 1'b0;
    rx_word_valid = 1'b0;
    rx_word = 9'h155;
    tx_word_taken = 1'b0;
    rx_word_taken_n = 1'b1;
  end
  // last bit sampled a cycle before the word moves in
  task automatic frame(input logic [8:0] w, input logic bad);
    @(posedge hclk);
    rx_word_taken_n <= 1'b0;
    rx_last_bit_sampled <= 1'b1;
    rx_parity_bad <= bad;
    @(posedge hclk);
    rx_last_bit_sampled <= 1'b0;
    rx_parity_bad <= 1'b0;
    rx_word_valid <= 1'b1;
    rx_word <= w;
    @(posedge hclk);
    rx_word_valid <= 1'b0;
    rx_word <= ~w;
    rx_word_taken_n <= 1'b1;
  endtask
  always @(posedge hclk) begin
    if (tx_word_valid === 1'b1 && !tx_word_taken) begin
      repeat (take_wait) @(posedge hclk);
      tx_seen <= tx_word;
      tx_word_taken <= 1'b1;
      @(posedge hclk);
      tx_word_taken <= 1'b0;
    end
  end
endmodule

// ==== dv/udrq_top_bench.sv ====
// Purpose: self-checking bench for the uart data and receive queue registers
// Assumes: zero wait AHB-Lite slave, link model on the far side
// Notes:   parity is even over the character bits below the top bit
`timescale 1ns/1ps
module udrq_top_bench;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, hready;
  logic        rx_last_bit_sampled, rx_parity_bad, rx_word_valid, tx_word_valid;
  logic        tx_word_taken, rx_word_taken_n, request_to_send_out_n, irq;
  logic [8:0]  rx_word, tx_word;
  logic [4:0]  nack_start_sixteenths;
  int          num_errors = 0;
  int          checked = 0;
  assign hready = hreadyout;
  udrq_top i_udrq_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rx_last_bit_sampled,
    .rx_parity_bad, .rx_word_valid, .rx_word, .tx_word_valid, .tx_word,
    .tx_word_taken, .rx_word_taken_n, .nack_start_sixteenths,
    .request_to_send_out_n, .irq);
  udrq_link_model i_udrq_link_model (.hclk, .tx_word_valid, .tx_word,
    .rx_last_bit_sampled, .rx_parity_bad, .rx_word_valid, .rx_word,
    .tx_word_taken, .rx_word_taken_n);
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, r);
  endtask
  task automatic take_wait;
    for (int i = 0; i < 40 && tx_word_taken !== 1'b1; i++) @(posedge hclk);
    @(posedge hclk);
  endtask
  task automatic t_reset;
    rd(8'hd0, 32'h0000_0400, "rxq_cs");
    rd(8'hc0, 32'h0, "coherence");
    rd(8'h80, 32'h0, "unmapped");
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic t_rx;
    bus(1'b1, 8'h2c, 32'h1);
    bus(1'b1, 8'hc0, 32'hffff_fefe);
    rd(8'hc0, 32'h0, "coherence");
    i_udrq_link_model.frame(9'h0a5, 1'b1);
    rd(8'hc0, 32'h100, "early parity");
    chk("rts_n", 32'h1, {31'h0, request_to_send_out_n});
    rd(8'h24, 32'h0a5, "rx char");
    repeat (2) @(posedge hclk);
    chk("rts_n", 32'h0, {31'h0, request_to_send_out_n});
    bus(1'b1, 8'hc0, 32'h0);
    rd(8'hc0, 32'h0, "early parity");
  endtask
  task automatic t_ovr;
    bus(1'b1, 8'h38, 32'h2);
    bus(1'b0, 8'h34, 32'h0);
    i_udrq_link_model.frame(9'h011, 1'b0);
    i_udrq_link_model.frame(9'h022, 1'b0);
    bus(1'b0, 8'h30, 32'h0);
    chk("overrun", 32'h5, r & 32'h5);
    chk("irq", 32'h1, {31'h0, irq});
    rd(8'h34, 32'h3, "int status");
    repeat (2) @(posedge hclk);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1'b1, 8'h30, 32'h4);
    bus(1'b1, 8'h2c, 32'h11);
    rd(8'h30, 32'h2, "flushed status");
  endtask
  task automatic t_tx;
    i_udrq_link_model.take_wait = 4;
    bus(1'b1, 8'h28, 32'h07f);
    bus(1'b1, 8'h28, 32'h011);
    take_wait();
    chk("tx 8 bit", 32'h0ff, {23'h0, i_udrq_link_model.tx_seen});
    @(posedge hclk);
    chk("tx idle", 32'h0, {31'h0, tx_word_valid});
    i_udrq_link_model.take_wait = 0;
    bus(1'b1, 8'h2c, 32'h3);
    bus(1'b1, 8'h28, 32'h103);
    take_wait();
    chk("tx 9 bit", 32'h003, {23'h0, i_udrq_link_model.tx_seen});
  endtask
  task automatic t_queue;
    bus(1'b1, 8'h2c, 32'h0);
    bus(1'b1, 8'hd0, 32'h100);
    i_udrq_link_model.frame(9'h033, 1'b0);
    bus(1'b0, 8'hd0, 32'h0);
    chk("idle queue", 32'h400, r & 32'h7c00);
    bus(1'b0, 8'h24, 32'h0);
    bus(1'b1, 8'h2c, 32'h4);
    bus(1'b1, 8'hd0, 32'h300);
    bus(1'b1, 8'h38, 32'h8);
    for (int i = 1; i <= 4; i++) i_udrq_link_model.frame(9'(i), 1'b0);
    rd(8'hd0, 32'h0000_cb00, "full queue");
    chk("irq", 32'h1, {31'h0, irq});
    for (int i = 1; i <= 4; i++) rd(8'h24, i, "queue pop");
    rd(8'hd0, 32'h0000_0700, "empty queue");
    bus(1'b1, 8'hd0, 32'h0);
  endtask
  task automatic t_nack;
    logic seen;
    bus(1'b1, 8'h2c, 32'h9);
    for (int en = 0; en < 2; en++) begin
      bus(1'b1, 8'hd0, en);
      seen = 1'b0;
      fork
        i_udrq_link_model.frame(9'h0c1, 1'b1);
        repeat (6) @(posedge hclk) if (nack_start_sixteenths === 5'h0f) seen = 1'b1;
      join
      chk("early nack", en, {31'h0, seen});
      bus(1'b0, 8'h24, 32'h0);
    end
  endtask
  task automatic t_rts;
    bus(1'b1, 8'h2c, 32'h1);
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, 8'hc0, m);
      fork
        i_udrq_link_model.frame(9'h055, 1'b0);
        begin
          do @(posedge hclk); while (rx_word_valid !== 1'b1);
          @(posedge hclk);
          chk("rts_n mode", m, {31'h0, request_to_send_out_n});
        end
      join
      bus(1'b0, 8'h24, 32'h0);
    end
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_rx();
    t_ovr();
    t_tx();
    t_queue();
    t_nack();
    t_rts();
    test_done();
  end
  initial begin
    #1000000;
    num_errors++;
    test_done();
  end
endmodule
